// ### shared/converter_state_sequencer_regs.vh
// offsets, fields, reset values and timing counts of the state sequencer
`ifndef CONVERTER_STATE_SEQUENCER_REGS_VH
`define CONVERTER_STATE_SEQUENCER_REGS_VH

// register byte offsets
`define CSS_CTRL_OFS 8'h00
`define CSS_STATUS_OFS 8'h04
`define CSS_FAULT_OFS 8'h08

// control register fields
`define CSS_CTRL_RUN_BIT 0
`define CSS_CTRL_AUTOFREQ_BIT 1
`define CSS_CTRL_BYPASS_BIT 2
`define CSS_CTRL_DIR_BIT 3
`define CSS_CTRL_USONIC_BIT 4
`define CSS_CTRL_RESET 32'h0000_0000

// fault flag positions
`define CSS_FLT_THERMAL 0
`define CSS_FLT_OV 1
`define CSS_FLT_UV 2
`define CSS_FLT_BOOT 3
`define CSS_FLT_TIMER 4
`define CSS_FLT_PGOOD 5
`define CSS_FLT_FLYING_CAPACITOR 6
`define CSS_FLT_WDOG 7
`define CSS_FLT_OCP 8
`define CSS_FLT_W 9

// timing: clock in MHz, times in microseconds
`define CSS_CLK_MHZ 125
`define CSS_FAULT_DWELL_US 1000
`define CSS_RAMP_US 20000
`define CSS_OTP_CYCLES 16
`define CSS_SW_DIV 21
`define CSS_AXI_OKAY 2'b00
`define CSS_AXI_SLVERR 2'b10

`endif

// ### logic/converter_state_sequencer.v
// top-level operating state machine of the switched-capacitor converter
`timescale 1ns/1ps
`include "converter_state_sequencer_regs.vh"

// Contract
// - after start-up, fixed or automatic frequency chosen by a host bit.
// - drive two phases with interleaved switching.
// - switching frequency from oscillator; optional spread spectrum via OTP.
// - auto mode: optional ultrasonic floor, CCM at high load, DCM at low.
// - multiply mode uses CCM only and ignores frequency-mode bit.
// - supply below power-down threshold forces OFF until power recovers.
// - rising supply: OTP load, then POWERDOWN, STANDBY or ACTIVE.
// - POWERDOWN: no switching, flying capacitors disconnected.
// - leave POWERDOWN on key press, or rising level in level mode.
// - STANDBY: converter off, supervision and host interface stay alive.
// - host run bit moves between STANDBY and ACTIVE.
// - any supervision flag sends device to FAULT from STANDBY or ACTIVE.
// - long key press in edge key style forces FAULT for a power cycle.
// - stay in FAULT at least the dwell, longer while flags assert.
// - after FAULT clears, repeat OTP read, then next state by settings.
// - entering ACTIVE turns converter on in configured mode.
// - switching: two switches on, two off, polarity alternates.
// - bypass: all high-side switches on, both power-good outputs high.
// - mode decode of control bits [3:2]: 00 divide, 01 forward bypass, 10 multiply, 11 reverse bypass.
// - input valid only within the mode-specific rail window.
// - mode bit changes are applied only while converter is off.
// - ramp timer checks start-up; failure blocks regular switching.
module converter_state_sequencer #(
	parameter FAULT_DWELL_CYCLES =
		`CSS_FAULT_DWELL_US * `CSS_CLK_MHZ,
	parameter RAMP_CYCLES = `CSS_RAMP_US * `CSS_CLK_MHZ,
	parameter LONG_PRESS_CYCLES = 32'd250000000
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// supply and key
	input wire supply_above_rising,
	input wire supply_below_falling,
	input wire key_pin,
	input wire level_enable_style,
	input wire otp_run_default,
	input wire otp_spread_enable,
	// analog supervision
	input wire [8:0] fault_flags_raw,
	input wire high_rail_valid,
	input wire low_rail_valid,
	input wire ratio_reached,
	input wire light_load,
	// converter outputs
	output reg [3:0] phase_a_switches,
	output reg [3:0] phase_b_switches,
	output reg flying_cap_connect,
	output reg pgood_force_high,
	output reg dcm_enable,
	output reg converter_on,
	output reg otp_load_strobe,
	output reg [5:0] state_code
);

// ==========================================================
// states
localparam ST_OFF = 6'b000001;
localparam ST_OTP = 6'b000010;
localparam ST_PDOWN = 6'b000100;
localparam ST_STBY = 6'b001000;
localparam ST_ACT = 6'b010000;
localparam ST_FAULT = 6'b100000;

// ==========================================================
// synchronised inputs
reg [8:0] flt_s1_ff, flt_ff;
reg key_s1_ff, key_ff, key_d_ff;

always @(posedge aclk) begin
	if (!aresetn) begin
		flt_s1_ff <= 9'h000;
		flt_ff <= 9'h000;
		key_s1_ff <= 1'b0;
		key_ff <= 1'b0;
		key_d_ff <= 1'b0;
	end else begin
		flt_s1_ff <= fault_flags_raw;
		flt_ff <= flt_s1_ff;
		key_s1_ff <= key_pin;
		key_ff <= key_s1_ff;
		key_d_ff <= key_ff;
	end
end

wire key_rise = key_ff & ~key_d_ff;

// ==========================================================
// register file
reg run_ff, autofreq_ff, bypass_ff, dir_ff, usonic_ff;
reg mode_byp_ff, mode_dir_ff;
reg [8:0] fault_seen_ff;
reg aw_ff, w_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg [5:0] state_ff, nxt_state;
reg ramp_ok_ff;

assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
assign s_axi_wready = ~w_ff & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire wr_go = aw_ff & w_ff & ~s_axi_bvalid;
wire wr_ctrl = wr_go & (awaddr_ff == `CSS_CTRL_OFS) & wstrb_ff[0];
wire wr_fault = wr_go & (awaddr_ff == `CSS_FAULT_OFS);
wire [8:0] flt_clr = wr_fault ? wdata_ff[8:0] : 9'h000;

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_ff <= 1'b0;
		w_ff <= 1'b0;
		awaddr_ff <= 8'h00;
		wdata_ff <= 32'h0000_0000;
		wstrb_ff <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CSS_AXI_OKAY;
		run_ff <= 1'b0;
		autofreq_ff <= 1'b0;
		bypass_ff <= 1'b0;
		dir_ff <= 1'b0;
		usonic_ff <= 1'b0;
		fault_seen_ff <= 9'h000;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		if (wr_go) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_ff == `CSS_CTRL_OFS ||
				awaddr_ff == `CSS_FAULT_OFS ||
				awaddr_ff == `CSS_STATUS_OFS) ?
				`CSS_AXI_OKAY : `CSS_AXI_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		if (wr_ctrl) begin
			run_ff <= wdata_ff[`CSS_CTRL_RUN_BIT];
			autofreq_ff <= wdata_ff[`CSS_CTRL_AUTOFREQ_BIT];
			bypass_ff <= wdata_ff[`CSS_CTRL_BYPASS_BIT];
			dir_ff <= wdata_ff[`CSS_CTRL_DIR_BIT];
			usonic_ff <= wdata_ff[`CSS_CTRL_USONIC_BIT];
		end else if (state_ff == ST_OTP) begin
			run_ff <= otp_run_default;
		end
		// sticky fault record: set wins over write-one clear
		fault_seen_ff <= (fault_seen_ff & ~flt_clr) | flt_ff;
	end
end

// read channel
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `CSS_AXI_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= `CSS_AXI_OKAY;
		case (s_axi_araddr)
		`CSS_CTRL_OFS: s_axi_rdata <= {27'h0, usonic_ff, dir_ff,
			bypass_ff, autofreq_ff, run_ff};
		`CSS_STATUS_OFS: s_axi_rdata <= {22'h0, mode_dir_ff,
			mode_byp_ff, converter_on, ramp_ok_ff, state_ff};
		`CSS_FAULT_OFS: s_axi_rdata <= {23'h0, fault_seen_ff};
		default: begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CSS_AXI_SLVERR;
		end
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

// ==========================================================
// timers
reg [31:0] tmr_ff;
reg [31:0] key_cnt_ff;
reg [3:0] otp_cnt_ff;

wire long_press = key_ff & ~level_enable_style &
	(key_cnt_ff >= LONG_PRESS_CYCLES);
wire any_fault = |flt_ff;
wire input_ok = mode_dir_ff ? low_rail_valid : high_rail_valid;
// wake event
// a press reads high in both key styles, so one edge serves both
wire wake = key_rise;
wire go_on = run_ff & input_ok;

always @(posedge aclk) begin
	if (!aresetn) begin
		key_cnt_ff <= 32'h0000_0000;
	end else if (!key_ff) begin
		key_cnt_ff <= 32'h0000_0000;
	end else if (key_cnt_ff != 32'hFFFF_FFFF) begin
		key_cnt_ff <= key_cnt_ff + 32'h0000_0001;
	end
end

// ==========================================================
// state machine
always @* begin
	nxt_state = state_ff;
	case (state_ff)
	ST_OFF: begin
		if (supply_above_rising)
			nxt_state = ST_OTP;
	end
	ST_OTP: begin
		if (otp_cnt_ff == `CSS_OTP_CYCLES - 1)
			nxt_state = level_enable_style && !key_ff ?
				ST_PDOWN : (otp_run_default ? ST_ACT : ST_STBY);
	end
	ST_PDOWN: begin
		if (wake)
			nxt_state = run_ff ? ST_ACT : ST_STBY;
	end
	ST_STBY: begin
		if (any_fault)
			nxt_state = ST_FAULT;
		else if (go_on)
			nxt_state = ST_ACT;
	end
	ST_ACT: begin
		if (any_fault || !input_ok)
			nxt_state = ST_FAULT;
		else if (!run_ff)
			nxt_state = ST_STBY;
	end
	ST_FAULT: begin
		if (tmr_ff >= FAULT_DWELL_CYCLES - 1 && !any_fault)
			nxt_state = ST_OTP;
	end
	default: nxt_state = ST_OFF;
	endcase
	if (long_press && state_ff != ST_OFF && state_ff != ST_FAULT)
		nxt_state = ST_FAULT;
	if (supply_below_falling)
		nxt_state = ST_OFF;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		state_ff <= ST_OFF;
		tmr_ff <= 32'h0000_0000;
		otp_cnt_ff <= 4'h0;
		ramp_ok_ff <= 1'b0;
		otp_load_strobe <= 1'b0;
		state_code <= ST_OFF;
	end else begin
		state_ff <= nxt_state;
		state_code <= nxt_state;
		otp_load_strobe <= (nxt_state == ST_OTP) &&
			(state_ff != ST_OTP);
		tmr_ff <= (nxt_state != state_ff) ? 32'h0000_0000 :
			tmr_ff + 32'h0000_0001;
		otp_cnt_ff <= (state_ff == ST_OTP) ? otp_cnt_ff + 4'h1 :
			4'h0;
		if (state_ff != ST_ACT)
			ramp_ok_ff <= 1'b0;
		else if (ratio_reached && tmr_ff < RAMP_CYCLES)
			ramp_ok_ff <= 1'b1;
	end
end

// latch mode only when converter off
always @(posedge aclk) begin
	if (!aresetn) begin
		mode_byp_ff <= 1'b0;
		mode_dir_ff <= 1'b0;
	end else if (!converter_on) begin
		mode_byp_ff <= bypass_ff;
		mode_dir_ff <= dir_ff;
	end
end

// ==========================================================
// switching clock with spread spectrum
reg [5:0] div_ff;
reg [3:0] lfsr_ff;
reg phase_ff;
wire [31:0] div_sum = `CSS_SW_DIV + (otp_spread_enable ?
	{29'h0000_0000, lfsr_ff[2:0]} : 32'h0000_0000);
wire [5:0] div_top = div_sum[5:0];

always @(posedge aclk) begin
	if (!aresetn) begin
		div_ff <= 6'd0;
		lfsr_ff <= 4'h1;
		phase_ff <= 1'b0;
	end else if (div_ff >= div_top) begin
		div_ff <= 6'd0;
		lfsr_ff <= {lfsr_ff[2:0], lfsr_ff[3] ^ lfsr_ff[2]};
		// skip pulses at light load unless floor forced
		if (!(autofreq_ff && !mode_dir_ff && light_load &&
			!usonic_ff && lfsr_ff[0]))
			phase_ff <= ~phase_ff;
	end else begin
		div_ff <= div_ff + 6'd1;
	end
end

// ==========================================================
// switch drive
// bypass bit picks bypass, direction bit multiply
wire active_on = (state_ff == ST_ACT);
wire sw_mode = active_on & ~mode_byp_ff & ramp_ok_ff;

always @(posedge aclk) begin
	if (!aresetn) begin
		phase_a_switches <= 4'h0;
		phase_b_switches <= 4'h0;
		flying_cap_connect <= 1'b0;
		pgood_force_high <= 1'b0;
		dcm_enable <= 1'b0;
		converter_on <= 1'b0;
	end else begin
		// converter on in active; off in standby
		converter_on <= active_on;
		flying_cap_connect <= active_on;
		pgood_force_high <= active_on & mode_byp_ff;
		// multiply forces CCM; auto mode picks DCM
		dcm_enable <= sw_mode & autofreq_ff & ~mode_dir_ff &
			light_load;
		if (active_on && mode_byp_ff) begin
			phase_a_switches <= 4'b0011;
			phase_b_switches <= 4'b0011;
		end else if (sw_mode) begin
			phase_a_switches <= phase_ff ? 4'b1010 : 4'b0101;
			phase_b_switches <= phase_ff ? 4'b0101 : 4'b1010;
		end else begin
			phase_a_switches <= 4'h0;
			phase_b_switches <= 4'h0;
		end
	end
end

endmodule

// ### tb/seq_props.sv
// port checker for the converter state sequencer
`timescale 1ns/1ps
module seq_props #(parameter FAULT_DWELL_CYCLES = 20) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// watched ports
	input wire supply_below_falling,
	input wire [8:0] fault_flags_raw,
	input wire [3:0] phase_a_switches,
	input wire [3:0] phase_b_switches,
	input wire flying_cap_connect,
	input wire pgood_force_high,
	input wire converter_on,
	input wire otp_load_strobe,
	input wire [5:0] state_code
);
	// ==========================================
	// helper logic
	reg [31:0] flt_cnt_ff;
	wire [7:0] sw = {phase_a_switches, phase_b_switches};
	always @(posedge aclk)
		flt_cnt_ff <= (!aresetn || !state_code[5]) ? 32'h0000_0000
			: flt_cnt_ff + 32'h0000_0001;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// properties
	property p_rst;
		disable iff (1'b0) !aresetn |=> state_code == 6'h01;
	endproperty
	a_rst: assert property (p_rst) else $error("state not off in reset");
	property p_off;
		supply_below_falling |-> ##[1:4] state_code == 6'h01;
	endproperty
	a_off: assert property (p_off) else $error("no off on low supply");
	property p_otp;
		otp_load_strobe |=> !otp_load_strobe;
	endproperty
	a_otp: assert property (p_otp) else $error("load strobe too long");
	property p_pdn;
		state_code == 6'h04 && $past(state_code) == 6'h04 |->
			!converter_on && !flying_cap_connect && sw == 8'h00;
	endproperty
	a_pdn: assert property (p_pdn) else $error("power stage on in pdown");
	property p_stb;
		state_code == 6'h08 && $past(state_code) == 6'h08 |->
			!converter_on && sw == 8'h00;
	endproperty
	a_stb: assert property (p_stb) else $error("converter on in standby");
	property p_flt;
		state_code[4] && |fault_flags_raw |-> ##[1:4] state_code[5];
	endproperty
	a_flt: assert property (p_flt) else $error("flag did not fault");
	property p_dwl;
		$fell(state_code[5]) |-> flt_cnt_ff >= FAULT_DWELL_CYCLES;
	endproperty
	a_dwl: assert property (p_dwl) else $error("fault left too early");
	property p_byp;
		pgood_force_high && sw != 8'h00 |-> $countones(sw) == 4;
	endproperty
	a_byp: assert property (p_byp) else $error("bypass switch count");
	property p_alt;
		!pgood_force_high && $changed(phase_a_switches) &&
			phase_a_switches != 4'h0 && $past(phase_a_switches) != 4'h0
			|-> phase_a_switches == ~$past(phase_a_switches);
	endproperty
	a_alt: assert property (p_alt) else $error("phase not reversed");
	c_flt: cover property (state_code[5]);
	c_byp: cover property (pgood_force_high && sw != 8'h00);
	c_pdn: cover property (state_code == 6'h04);
endmodule

bind converter_state_sequencer seq_props #(
	.FAULT_DWELL_CYCLES(FAULT_DWELL_CYCLES)) u_props (.aclk(aclk),
	.aresetn(aresetn), .supply_below_falling(supply_below_falling),
	.fault_flags_raw(fault_flags_raw), .phase_a_switches(phase_a_switches),
	.phase_b_switches(phase_b_switches),
	.flying_cap_connect(flying_cap_connect),
	.pgood_force_high(pgood_force_high), .converter_on(converter_on),
	.otp_load_strobe(otp_load_strobe), .state_code(state_code));

// ### tb/power_stage_model.sv
// far-side power stage: output ratio settles some cycles after start
`timescale 1ns/1ps
module power_stage_model (
	// clock
	input wire aclk,
	// from sequencer and bench
	input wire converter_on,
	input wire stall,
	input wire hi_ok,
	input wire lo_ok,
	// to sequencer
	output reg ratio_reached = 1'b0,
	output wire high_rail_valid,
	output wire low_rail_valid,
	output wire light_load
);
	reg [3:0] cnt_ff = 4'h0;
	// rails follow the bench window flags, load kept light
	assign high_rail_valid = hi_ok;
	assign low_rail_valid = lo_ok;
	assign light_load = 1'b1;
	// stall models a start-up that never reaches the ratio
	always @(posedge aclk) begin
		cnt_ff <= converter_on ? cnt_ff + {3'h0, cnt_ff != 4'hf} : 4'h0;
		ratio_reached <= !stall && converter_on && cnt_ff > 4'h7;
	end
endmodule

// ### tb/tb.sv
// self-checking bench for the converter state sequencer
`timescale 1ns/1ps
module tb;
	reg aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	reg bready = 1'b0, arvalid = 1'b0, rready = 1'b0, stall = 1'b0;
	reg sup_up = 1'b1, sup_dn = 1'b0, key = 1'b1, lvl = 1'b1;
	reg spread = 1'b0, hi_ok = 1'b1, lo_ok = 1'b1, done = 1'b0;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg [31:0] wdata = 32'h0000_0000, rd;
	reg [8:0] flags = 9'h000;
	reg [1:0] rs;
	reg [6:0] rows [0:4];
	wire awready, wready, bvalid, arready, rvalid, ratio, hrv, lrv, light;
	wire fcc, pgf, dcm, con, otp;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] pa, pb;
	wire [5:0] st;
	integer n_fail = 0, cmp_count = 0, i, j, k;
	always #4 aclk = ~aclk;
	converter_state_sequencer #(.FAULT_DWELL_CYCLES(20), .RAMP_CYCLES(50),
		.LONG_PRESS_CYCLES(30)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .supply_above_rising(sup_up),
		.supply_below_falling(sup_dn), .key_pin(key),
		.level_enable_style(lvl), .otp_run_default(1'b0),
		.otp_spread_enable(spread), .fault_flags_raw(flags),
		.high_rail_valid(hrv), .low_rail_valid(lrv), .ratio_reached(ratio),
		.light_load(light), .phase_a_switches(pa), .phase_b_switches(pb),
		.flying_cap_connect(fcc), .pgood_force_high(pgf),
		.dcm_enable(dcm), .converter_on(con), .otp_load_strobe(otp),
		.state_code(st));
	power_stage_model psm (.aclk(aclk), .converter_on(con), .stall(stall),
		.hi_ok(hi_ok), .lo_ok(lo_ok),
		.ratio_reached(ratio), .high_rail_valid(hrv),
		.low_rail_valid(lrv), .light_load(light));
	// ==========================================
	// tasks
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", cmp_count, n_fail);
			if (n_fail == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task tmo;
		begin
			n_fail = n_fail + 1;
			$display("BAD wait expected done seen timeout");
			wrap_up;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (e !== g) begin
				n_fail = n_fail + 1;
				$display("BAD %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task axw(input [7:0] a, input [31:0] d);
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			done = 1'b0;
			for (k = 0; k < 100 && !done; k = k + 1) begin
				@(posedge aclk);
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				if (bvalid) begin
					bready <= 1'b0;
					done = 1'b1;
				end
			end
			if (!done)
				tmo;
			@(posedge aclk);
		end
	endtask
	task axr(input [7:0] a);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			done = 1'b0;
			for (k = 0; k < 100 && !done; k = k + 1) begin
				@(posedge aclk);
				if (arready)
					arvalid <= 1'b0;
				if (rvalid) begin
					rready <= 1'b0;
					rd = rdata;
					rs = rresp;
					done = 1'b1;
				end
			end
			if (!done)
				tmo;
			@(posedge aclk);
		end
	endtask
	task wait_st(input [5:0] s);
		begin
			for (k = 0; k < 300 && st !== s; k = k + 1)
				@(posedge aclk);
			if (st !== s)
				tmo;
		end
	endtask
	task wait_sw;
		begin
			for (k = 0; k < 300 && {pa, pb} === 8'h00; k = k + 1)
				@(posedge aclk);
			if ({pa, pb} === 8'h00)
				tmo;
			repeat (4) @(posedge aclk);
		end
	endtask
	// ==========================================
	// main sequence: row = control bits, power-good, dcm
	initial begin
		rows[0] = {5'h02, 1'b0, 1'b1};
		rows[1] = {5'h0a, 1'b0, 1'b0};
		rows[2] = {5'h06, 1'b1, 1'b0};
		rows[3] = {5'h0e, 1'b1, 1'b0};
		rows[4] = {5'h12, 1'b0, 1'b1};
		repeat (16) @(posedge aclk);
		chk("state", 6'h01, st);
		aresetn <= 1'b1;
		wait_st(6'h08);
		for (i = 0; i < 5; i = i + 1) begin
			spread <= i[0];
			axw(8'h00, {27'h000_0000, rows[i][6:2]});
			axw(8'h00, {27'h000_0000, rows[i][6:2] | 5'h01});
			wait_sw;
			chk("pgood", rows[i][1], pgf);
			chk("dcm", rows[i][0], dcm);
			axr(8'h04);
			chk("bypass", rows[i][4], rd[8]);
			chk("dir", rows[i][5], rd[9]);
			axw(8'h00, 32'h0000_0000);
			wait_st(6'h08);
			$display("mode row %0d done", i);
		end
		axw(8'h00, 32'h0000_0003);
		wait_sw;
		axw(8'h00, 32'h0000_0007);
		repeat (8) @(posedge aclk);
		chk("pgood held", 0, pgf);
		axw(8'h00, 32'h0000_0000);
		wait_st(6'h08);
		$display("mode lock done");
		stall <= 1'b1;
		axw(8'h00, 32'h0000_0003);
		wait_st(6'h10);
		repeat (80) @(posedge aclk);
		chk("switches", 0, {pa, pb});
		chk("state", 6'h10, st);
		stall <= 1'b0;
		axw(8'h00, 32'h0000_0000);
		wait_st(6'h08);
		$display("ramp fail done");
		for (i = 0; i < 9; i = i + 1) begin
			axw(8'h00, 32'h0000_0001);
			wait_st(6'h10);
			flags <= 9'h001 << i;
			wait_st(6'h20);
			flags <= 9'h000;
			for (j = 0; j < 300 && st[5]; j = j + 1)
				@(posedge aclk);
			chk("dwell", 1, j >= 20);
			wait_st(6'h08);
		end
		$display("fault flags done");
		axr(8'h08);
		chk("fault rec", 32'h0000_01ff, rd);
		axw(8'h08, 32'h0000_01ff);
		axr(8'h08);
		chk("fault clr", 32'h0000_0000, rd);
		axr(8'h0c);
		chk("resp", 2'b10, rs);
		chk("rdata", 0, rd);
		axw(8'h00, 32'h0000_0008);
		hi_ok <= 1'b0;
		axw(8'h00, 32'h0000_0009);
		wait_st(6'h10);
		repeat (8) @(posedge aclk);
		chk("window", 6'h10, st);
		lo_ok <= 1'b0;
		wait_st(6'h20);
		hi_ok <= 1'b1;
		lo_ok <= 1'b1;
		wait_st(6'h08);
		$display("input window done");
		key <= 1'b0;
		repeat (4) @(posedge aclk);
		lvl <= 1'b0;
		repeat (4) @(posedge aclk);
		key <= 1'b1;
		wait_st(6'h20);
		key <= 1'b0;
		wait_st(6'h08);
		lvl <= 1'b1;
		$display("long press done");
		key <= 1'b0;
		sup_up <= 1'b0;
		sup_dn <= 1'b1;
		wait_st(6'h01);
		sup_dn <= 1'b0;
		sup_up <= 1'b1;
		wait_st(6'h04);
		key <= 1'b1;
		wait_st(6'h08);
		$display("supply and key done");
		wrap_up;
	end
endmodule
